// file: design/torque_bias_defines.svh
// How it works
// - Selector 9999: no bias, rated torque 100%
// - Selector 0: stored settings chosen by contacts
// - Selector 1/2: analog bias, reverse/forward lift
// - Selector 3: auto-set calibration and balance voltage
// - Setting 600-999 means -400% to -1%
// - Setting 1000-1400 means 0% to 400%
// - Setting 9999 means no bias
// - Contacts: off/off 0%, A one, B two, both three
// - Rise filter 0-5 s first order; 9999 is 0
// - Hold bias alone for hold time; 9999 is 0
// - Balanced-load voltage 0-10 V; 9999 is 0 V
// - Fall bias point 0-400%; 9999 uses rise point
// - Fall gain point 0-400%; 9999 uses rise point
// - Function 6 makes terminal a torque command
// - Override main speed from terminal gives 0 Hz
// - Without pre-excitation bias starts with start signal
`ifndef TORQUE_BIAS_DEFINES_SVH
`define TORQUE_BIAS_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_SOURCE 8'h00
`define OFF_BIAS_ONE 8'h04
`define OFF_BIAS_TWO 8'h08
`define OFF_BIAS_THREE 8'h0C
`define OFF_RISE_FILTER 8'h10
`define OFF_HOLD_TIME 8'h14
`define OFF_BALANCE 8'h18
`define OFF_FALL_BIAS 8'h1C
`define OFF_FALL_GAIN 8'h20
`define OFF_RISE_BIAS_CAL 8'h24
`define OFF_RISE_GAIN_CAL 8'h28
`define OFF_TERM_FUNC 8'h2C
`define OFF_INPUT_SEL 8'h30
`define OFF_STATUS 8'h34

// ----------------------------------------
// Values and reset values
// ----------------------------------------
`define UNSET 16'h270F
`define SEL_CONTACT 16'h0000
`define SEL_AN_REV 16'h0001
`define SEL_AN_FWD 16'h0002
`define SEL_AUTO 16'h0003
`define BIAS_MIN 16'h0258
`define BIAS_MAX 16'h0578
`define BIAS_ZERO 16'h03E8
`define TERM_TORQUE 16'h0006
`define RISE_BIAS_RST 16'h0000
`define RISE_GAIN_RST 16'h0064
`define AUTO_BIAS_PCT 16'h0000
`define AUTO_GAIN_PCT 16'h0064
`define TERM_FUNC_RST 16'h0000
`define FILTER_MAX_MS 16'h1388
`define ANALOG_FULL 16'h03E8
`define RECIP_SHIFT 20
`define RECIP_FULL 40'h0000000419

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 100
`define TICK_US 10
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
`define TICKS_PER_MS (1000 / `TICK_US)

`endif

// file: design/torque_bias_pkg.sv
package torque_bias_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT_EXCITE = 2'b01,
        ST_HOLD = 2'b10,
        ST_DONE = 2'b11
    } bias_state_e;

    typedef enum logic [2:0] {
        SRC_OFF = 3'b000,
        SRC_CONTACT = 3'b001,
        SRC_AN_REV = 3'b010,
        SRC_AN_FWD = 3'b011,
        SRC_AUTO = 3'b100
    } bias_src_e;

endpackage

// file: design/start_torque_bias_selector.sv
`include "torque_bias_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module start_torque_bias_selector (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic bias_select_in_a,
    input wire logic bias_select_in_b,
    input wire logic startIn,
    input wire logic preExciteIn,
    input wire logic runForward,
    input wire logic [9:0] analogLevel,
    input wire logic signed [12:0] torqueCmdIn,
    output logic signed [13:0] torqueRef,
    output logic biasActive,
    output logic ratedTorqueOnly,
    output logic auxFreqEnable,
    output logic mainSpeedZero
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [3:0] pinMeta_q;
    logic [3:0] pinSync_q;
    logic [3:0] pinRaw;
    assign pinRaw = {preExciteIn, startIn, bias_select_in_b, bias_select_in_a};

    logic selA, selB, startLvl, preExcite, startPrev_q, startRise;
    assign {preExcite, startLvl, selB, selA} = pinSync_q;
    assign startRise = startLvl && !startPrev_q;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pinMeta_q <= 4'h0;
            pinSync_q <= 4'h0;
            startPrev_q <= 1'b0;
        end else begin
            pinMeta_q <= pinRaw;
            pinSync_q <= pinMeta_q;
            startPrev_q <= startLvl;
        end
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [15:0] source_q, biasOne_q, biasTwo_q, biasThree_q;
    logic [15:0] riseFilter_q, holdTime_q, balance_q;
    logic [15:0] fallBias_q, fallGain_q, riseBiasCal_q, riseGainCal_q;
    logic [15:0] termFunc_q;
    logic overrideMain_q, calDone_q;
    logic wrTake, rdTake, calCapture;
    logic [15:0] wrVal, wrMask;
    torque_bias_pkg::bias_state_e state_q;
    torque_bias_pkg::bias_src_e srcMode;
    logic signed [11:0] filt_q;
    // Both write channels are taken together; one response in flight
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_wready = s_axi_awready;
    assign s_axi_arready = !s_axi_rvalid;
    assign wrTake = s_axi_awready;
    assign rdTake = s_axi_arvalid && s_axi_arready;
    assign wrMask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    assign wrVal = s_axi_wdata[15:0] & wrMask;
    function automatic logic [15:0] merge(input logic [15:0] old);
        return (old & ~wrMask) | wrVal;
    endfunction
    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= `OFF_STATUS);
    endfunction

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            {source_q, biasOne_q, biasTwo_q, biasThree_q, riseFilter_q,
             holdTime_q, balance_q, fallBias_q, fallGain_q} <= {9{`UNSET}};
            riseBiasCal_q <= `RISE_BIAS_RST;
            riseGainCal_q <= `RISE_GAIN_RST;
            termFunc_q <= `TERM_FUNC_RST;
            overrideMain_q <= 1'b0;
        end else begin
            if (wrTake) begin
                unique case (s_axi_awaddr)
                    `OFF_SOURCE: source_q <= merge(source_q);
                    `OFF_BIAS_ONE: biasOne_q <= merge(biasOne_q);
                    `OFF_BIAS_TWO: biasTwo_q <= merge(biasTwo_q);
                    `OFF_BIAS_THREE: biasThree_q <= merge(biasThree_q);
                    `OFF_RISE_FILTER: riseFilter_q <= merge(riseFilter_q);
                    `OFF_HOLD_TIME: holdTime_q <= merge(holdTime_q);
                    `OFF_BALANCE: balance_q <= merge(balance_q);
                    `OFF_FALL_BIAS: fallBias_q <= merge(fallBias_q);
                    `OFF_FALL_GAIN: fallGain_q <= merge(fallGain_q);
                    `OFF_RISE_BIAS_CAL: riseBiasCal_q <= merge(riseBiasCal_q);
                    `OFF_RISE_GAIN_CAL: riseGainCal_q <= merge(riseGainCal_q);
                    `OFF_TERM_FUNC: termFunc_q <= merge(termFunc_q);
                    `OFF_INPUT_SEL: begin
                        if (s_axi_wstrb[0]) begin
                            overrideMain_q <= s_axi_wdata[0];
                        end
                    end
                    default: ;
                endcase
            end
            // Load captured at start sets the calibration; wins over bus
            if (calCapture) begin
                balance_q <= {6'h00, analogLevel};
                riseBiasCal_q <= `AUTO_BIAS_PCT;
                riseGainCal_q <= `AUTO_GAIN_PCT;
            end
        end
    end

    // Done flag: set by calibration, cleared by a selector write; set wins
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            calDone_q <= 1'b0;
        end else if (calCapture) begin
            calDone_q <= 1'b1;
        end else if (wrTake && s_axi_awaddr == `OFF_SOURCE) begin
            calDone_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (wrTake) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (mapped(s_axi_awaddr) &&
                            s_axi_awaddr != `OFF_STATUS) ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else if (rdTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
            unique case (s_axi_araddr)
                `OFF_SOURCE: s_axi_rdata <= {16'h0000, source_q};
                `OFF_BIAS_ONE: s_axi_rdata <= {16'h0000, biasOne_q};
                `OFF_BIAS_TWO: s_axi_rdata <= {16'h0000, biasTwo_q};
                `OFF_BIAS_THREE: s_axi_rdata <= {16'h0000, biasThree_q};
                `OFF_RISE_FILTER: s_axi_rdata <= {16'h0000, riseFilter_q};
                `OFF_HOLD_TIME: s_axi_rdata <= {16'h0000, holdTime_q};
                `OFF_BALANCE: s_axi_rdata <= {16'h0000, balance_q};
                `OFF_FALL_BIAS: s_axi_rdata <= {16'h0000, fallBias_q};
                `OFF_FALL_GAIN: s_axi_rdata <= {16'h0000, fallGain_q};
                `OFF_RISE_BIAS_CAL: s_axi_rdata <= {16'h0000, riseBiasCal_q};
                `OFF_RISE_GAIN_CAL: s_axi_rdata <= {16'h0000, riseGainCal_q};
                `OFF_TERM_FUNC: s_axi_rdata <= {16'h0000, termFunc_q};
                `OFF_INPUT_SEL: s_axi_rdata <= {31'h00000000, overrideMain_q};
                `OFF_STATUS: s_axi_rdata <= {17'h00000, calDone_q, state_q,
                                             filt_q};
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Bias target
    // ----------------------------------------
    always_comb begin
        unique case (source_q)
            `SEL_CONTACT: srcMode = torque_bias_pkg::SRC_CONTACT;
            `SEL_AN_REV: srcMode = torque_bias_pkg::SRC_AN_REV;
            `SEL_AN_FWD: srcMode = torque_bias_pkg::SRC_AN_FWD;
            `SEL_AUTO: srcMode = torque_bias_pkg::SRC_AUTO;
            default: srcMode = torque_bias_pkg::SRC_OFF;
        endcase
    end

    // Out-of-range codes are treated like the unset value
    function automatic logic signed [11:0] storedPct(input logic [15:0] v);
        logic signed [16:0] d;
        d = $signed({1'b0, v}) - $signed({1'b0, `BIAS_ZERO});
        if (v >= `BIAS_MIN && v <= `BIAS_MAX) begin
            return d[11:0];
        end
        return 12'sh000;
    endfunction

    logic signed [11:0] contactPct, analogPct, targetPct;
    always_comb begin
        unique case ({selB, selA})
            2'b00: contactPct = 12'sh000;
            2'b01: contactPct = storedPct(biasOne_q);
            2'b10: contactPct = storedPct(biasTwo_q);
            default: contactPct = storedPct(biasThree_q);
        endcase
    end

    // Scaled reciprocal instead of a divide: may be off by one percent
    logic lowering;
    logic [15:0] ptBias, ptGain, balEff;
    logic signed [39:0] span, level, prod;
    always_comb begin
        lowering = (srcMode == torque_bias_pkg::SRC_AN_REV) ? runForward
                   : !runForward;
        ptBias = (lowering && fallBias_q != `UNSET) ? fallBias_q
                                                    : riseBiasCal_q;
        ptGain = (lowering && fallGain_q != `UNSET) ? fallGain_q
                                                    : riseGainCal_q;
        balEff = (balance_q == `UNSET) ? 16'h0000 : balance_q;
        span = $signed({24'h000000, ptGain}) - $signed({24'h000000, ptBias});
        level = $signed({30'h00000000, analogLevel})
              - $signed({24'h000000, balEff});
        prod = (span * level * $signed(`RECIP_FULL)) >>> `RECIP_SHIFT;
        analogPct = 12'(prod + $signed({24'h000000, ptBias}));
    end

    always_comb begin
        unique case (srcMode)
            torque_bias_pkg::SRC_CONTACT: targetPct = contactPct;
            torque_bias_pkg::SRC_AN_REV,
            torque_bias_pkg::SRC_AN_FWD: targetPct = analogPct;
            default: targetPct = 12'sh000;
        endcase
    end

    // ----------------------------------------
    // Start sequence and hold timer
    // ----------------------------------------
    logic [9:0] tickCnt_q;
    logic tick, biasMode;
    logic [22:0] holdCnt_q, holdTicks;
    assign tick = (tickCnt_q == 10'(`TICK_CYCLES - 1));
    assign biasMode = (srcMode == torque_bias_pkg::SRC_CONTACT) ||
                      (srcMode == torque_bias_pkg::SRC_AN_REV) ||
                      (srcMode == torque_bias_pkg::SRC_AN_FWD);
    assign holdTicks = (holdTime_q == `UNSET) ? 23'h000000
                     : 23'(holdTime_q * `TICKS_PER_MS);
    assign calCapture = startRise && (srcMode == torque_bias_pkg::SRC_AUTO);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tickCnt_q <= 10'h000;
        end else begin
            tickCnt_q <= tick ? 10'h000 : tickCnt_q + 10'h001;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= torque_bias_pkg::ST_IDLE;
            holdCnt_q <= 23'h000000;
        end else begin
            unique case (state_q)
                torque_bias_pkg::ST_IDLE: begin
                    holdCnt_q <= 23'h000000;
                    if (startRise && biasMode) begin
                        state_q <= preExcite ? torque_bias_pkg::ST_WAIT_EXCITE
                            : torque_bias_pkg::ST_HOLD;
                    end
                end
                torque_bias_pkg::ST_WAIT_EXCITE: begin
                    if (!startLvl) begin
                        state_q <= torque_bias_pkg::ST_IDLE;
                    end else if (!preExcite) begin
                        state_q <= torque_bias_pkg::ST_HOLD;
                    end
                end
                torque_bias_pkg::ST_HOLD: begin
                    if (!startLvl) begin
                        state_q <= torque_bias_pkg::ST_IDLE;
                    end else if (holdCnt_q >= holdTicks) begin
                        state_q <= torque_bias_pkg::ST_DONE;
                    end else if (tick) begin
                        holdCnt_q <= holdCnt_q + 23'h000001;
                    end
                end
                torque_bias_pkg::ST_DONE: begin
                    if (!startLvl) begin
                        state_q <= torque_bias_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Rise filter
    // ----------------------------------------
    // With a filter time set, slope capped at one percent per tick to keep the adder small
    logic [18:0] filtThr;
    logic signed [20:0] acc_q, accNext, thrS;
    logic [15:0] tauMs;
    assign tauMs = (riseFilter_q == `UNSET) ? 16'h0000
                 : (riseFilter_q > `FILTER_MAX_MS) ? `FILTER_MAX_MS
                 : riseFilter_q;
    assign filtThr = 19'(tauMs * `TICKS_PER_MS);
    assign thrS = $signed({2'b00, filtThr});
    assign accNext = acc_q + 21'(targetPct - filt_q);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            filt_q <= 12'sh000;
            acc_q <= 21'sh000000;
        end else if (state_q != torque_bias_pkg::ST_HOLD) begin
            filt_q <= 12'sh000;
            acc_q <= 21'sh000000;
        end else if (filtThr == 19'h00000) begin
            filt_q <= targetPct;
        end else if (tick) begin
            if (accNext >= thrS) begin
                filt_q <= filt_q + 12'sh001;
                acc_q <= accNext - thrS;
            end else if (accNext <= -thrS) begin
                filt_q <= filt_q - 12'sh001;
                acc_q <= accNext + thrS;
            end else begin
                acc_q <= accNext;
            end
        end
    end

    // ----------------------------------------
    // Torque path outputs
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            torqueRef <= 14'sh0000;
            biasActive <= 1'b0;
            ratedTorqueOnly <= 1'b1;
            auxFreqEnable <= 1'b1;
            mainSpeedZero <= 1'b0;
        end else begin
            torqueRef <= (state_q == torque_bias_pkg::ST_HOLD)
                       ? 14'(filt_q) : 14'(torqueCmdIn);
            biasActive <= (state_q == torque_bias_pkg::ST_HOLD);
            ratedTorqueOnly <= (srcMode == torque_bias_pkg::SRC_OFF);
            auxFreqEnable <= !((srcMode != torque_bias_pkg::SRC_OFF) &&
                               termFunc_q == `TERM_TORQUE);
            mainSpeedZero <= (srcMode != torque_bias_pkg::SRC_OFF) &&
                             termFunc_q == `TERM_TORQUE &&
                             overrideMain_q;
        end
    end

endmodule

`default_nettype wire

// file: verif/bias_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Contact, start and excitation pins
// ----------------------------------------
module bias_source_model (
    input wire logic core_clk,
    input wire logic [1:0] contactReq,
    input wire logic startReq,
    input wire logic exciteReq,
    output logic bias_select_in_a,
    output logic bias_select_in_b,
    output logic startIn,
    output logic preExciteIn
);
    // Pins start low so the synchronisers never see an unknown
    initial begin
        {bias_select_in_a, bias_select_in_b, startIn, preExciteIn} = 4'h0;
    end
    always @(posedge core_clk) begin
        bias_select_in_a <= contactReq[0];
        bias_select_in_b <= contactReq[1];
        startIn <= startReq;
        preExciteIn <= exciteReq;
    end
endmodule
`default_nettype wire

// file: verif/start_torque_bias_selector_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module bias_selector_checker (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic startIn,
    input wire logic preExciteIn,
    input wire logic signed [12:0] torqueCmdIn,
    input wire logic signed [13:0] torqueRef,
    input wire logic biasActive,
    input wire logic ratedTorqueOnly,
    input wire logic auxFreqEnable,
    input wire logic mainSpeedZero
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    sequence wrTake;
        s_axi_awvalid && s_axi_awready;
    endsequence
    // Seven edges cover two sync stages, state and output flop
    sequence startLow;
        !startIn [*7];
    endsequence
    sequence exciteOn;
        preExciteIn [*6];
    endsequence
    wr_resp_next_a: assert property (wrTake |=> s_axi_bvalid)
        else $error("write answer missing");
    wr_resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
    rd_resp_next_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read answer missing");
    rd_resp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid) else $error("read answer lost");
    rated_no_bias_a:
        assert property (ratedTorqueOnly |-> !biasActive)
        else $error("bias while rated only");
    pass_through_a:
        assert property (!biasActive && $past(rstn) |->
        torqueRef == $past(torqueCmdIn)) else $error("command not passed");
    start_abort_a:
        assert property (startLow |-> !biasActive)
        else $error("bias without start");
    start_first_a:
        assert property ($rose(biasActive) |-> $past(startIn, 2) &&
        $past(startIn, 3)) else $error("bias before start");
    excite_wait_a:
        assert property (exciteOn |-> !$rose(biasActive))
        else $error("bias during excitation");
    speed_zero_a:
        assert property (mainSpeedZero |-> !auxFreqEnable && !ratedTorqueOnly)
        else $error("main speed zero wrongly");
    aux_torque_a:
        assert property (!auxFreqEnable |-> !ratedTorqueOnly)
        else $error("terminal taken without bias");
endmodule
`default_nettype wire

// file: verif/start_torque_bias_selector_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "torque_bias_defines.svh"
// ----------------------------------------
// Bench top
// ----------------------------------------
module start_torque_bias_selector_tb_top;
    logic core_clk = 1'b0, rstn = 1'b0, runForward = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, biasActive, ratedTorqueOnly, auxFreqEnable;
    logic mainSpeedZero, bias_select_in_a, bias_select_in_b;
    logic startIn, preExciteIn, startReq = 1'b0, exciteReq = 1'b0;
    logic [1:0] s_axi_bresp, s_axi_rresp, contactReq = 2'h0;
    logic [9:0] analogLevel = 10'h000;
    logic signed [12:0] torqueCmdIn = 13'h0005;
    logic signed [13:0] torqueRef;
    logic [15:0] setv [3] = '{16'h0401, 16'h0258, 16'h0578};
    int failCount = 0, samplesChecked = 0;
    always #5 core_clk = ~core_clk;
    bias_source_model src_u (.core_clk, .contactReq, .startReq, .exciteReq,
        .bias_select_in_a, .bias_select_in_b, .startIn, .preExciteIn);
    start_torque_bias_selector dut_u (.core_clk, .rstn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .bias_select_in_a, .bias_select_in_b, .startIn, .preExciteIn,
        .runForward, .analogLevel, .torqueCmdIn, .torqueRef, .biasActive,
        .ratedTorqueOnly, .auxFreqEnable, .mainSpeedZero);
    task automatic check(input string what, input logic [31:0] seen, exp);
        samplesChecked++;
        if (seen !== exp) begin
            failCount++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        if (failCount == 0 && samplesChecked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                            input logic [1:0] er);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge core_clk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check("bresp", s_axi_bresp, er);
    endtask
    task automatic axiRead(input logic [7:0] a, input logic [31:0] ed,
                           input logic [1:0] er, input logic [31:0] m);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check("rresp", s_axi_rresp, er);
        check("rdata", s_axi_rdata & m, ed);
    endtask
    // Start, optionally behind excitation, judge bias, then abort early
    task automatic runStart(input logic [1:0] con, input logic signed [31:0]
                            exp, tol, input logic excite);
        int n;
        @(posedge core_clk);
        contactReq <= con;
        exciteReq <= excite;
        startReq <= 1'b1;
        if (excite) begin
            repeat (10) @(posedge core_clk);
            check("heldByExcite", biasActive, 1'b0);
            exciteReq <= 1'b0;
        end
        n = 0;
        while (biasActive !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        repeat (3) @(posedge core_clk);
        check("onset", n <= 8, 1'b1);
        check("biasActive", biasActive, 1'b1);
        check("torqueRef", (torqueRef >= exp - tol && torqueRef <= exp + tol)
            ? exp : torqueRef, exp);
        startReq <= 1'b0;
        torqueCmdIn <= torqueCmdIn + 13'sh1;
        repeat (8) @(posedge core_clk);
        check("released", biasActive, 1'b0);
        check("passThru", torqueRef, torqueCmdIn);
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        check("rated", ratedTorqueOnly, 1'b1);
        check("auxFreq", auxFreqEnable, 1'b1);
        axiRead(`OFF_SOURCE, `UNSET, 2'b00, 32'hFFFFFFFF);
        axiRead(`OFF_BIAS_THREE, `UNSET, 2'b00, 32'hFFFFFFFF);
        axiRead(8'h38, 32'h0, 2'b10, 32'hFFFFFFFF);
        axiWrite(`OFF_STATUS, 32'h1, 2'b10);
        axiWrite(`OFF_HOLD_TIME, 32'h1, 2'b00);
        axiWrite(`OFF_SOURCE, `SEL_CONTACT, 2'b00);
        for (int i = 0; i < 3; i++) begin
            axiWrite(`OFF_BIAS_ONE + 8'(4 * i), setv[i], 2'b00);
            runStart(2'(i + 1), setv[i] - `BIAS_ZERO, 0, 0);
        end
        runStart(2'b00, 0, 0, 1);
        axiWrite(`OFF_BIAS_TWO, `UNSET, 2'b00);
        runStart(2'b10, 0, 0, 0);
        axiWrite(`OFF_RISE_FILTER, 32'h1, 2'b00);
        runStart(2'b01, 0, 1, 0);
        axiWrite(`OFF_RISE_FILTER, `UNSET, 2'b00);
        axiWrite(`OFF_TERM_FUNC, `TERM_TORQUE, 2'b00);
        axiWrite(`OFF_INPUT_SEL, 32'h1, 2'b00);
        axiWrite(`OFF_SOURCE, `SEL_AN_REV, 2'b00);
        analogLevel <= 10'h1F4;
        repeat (2) @(posedge core_clk);
        check("auxFreq", auxFreqEnable, 1'b0);
        check("mainZero", mainSpeedZero, 1'b1);
        runStart(2'b00, 32'h64 * 32'h1F4 / `ANALOG_FULL, 1, 0);
        runForward <= 1'b1;
        axiWrite(`OFF_FALL_GAIN, 32'hC8, 2'b00);
        runStart(2'b00, 32'hC8 * 32'h1F4 / `ANALOG_FULL, 1, 0);
        axiWrite(`OFF_SOURCE, `SEL_AN_FWD, 2'b00);
        runStart(2'b00, 32'h64 * 32'h1F4 / `ANALOG_FULL, 1, 0);
        axiWrite(`OFF_SOURCE, `SEL_AUTO, 2'b00);
        analogLevel <= 10'h12C;
        startReq <= 1'b1;
        repeat (10) @(posedge core_clk);
        check("autoNoBias", biasActive, 1'b0);
        startReq <= 1'b0;
        axiRead(`OFF_BALANCE, 32'h12C, 2'b00, 32'hFFFFFFFF);
        axiRead(`OFF_STATUS, 32'h4000, 2'b00, 32'h4000);
        axiWrite(`OFF_SOURCE, `SEL_AN_REV, 2'b00);
        runStart(2'b00, 0, 1, 0);
        axiWrite(`OFF_SOURCE, `UNSET, 2'b00);
        repeat (3) @(posedge core_clk);
        check("rated", ratedTorqueOnly, 1'b1);
        check("auxFreq", auxFreqEnable, 1'b1);
        summarize();
    end
    // Cuts a hang short
    initial begin
        repeat (5000) @(posedge core_clk);
        failCount++;
        summarize();
    end
endmodule
bind start_torque_bias_selector bias_selector_checker chk_u (.core_clk,
    .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .startIn, .preExciteIn, .torqueCmdIn, .torqueRef,
    .biasActive, .ratedTorqueOnly, .auxFreqEnable, .mainSpeedZero);
`default_nettype wire
